/* File: rtl/chip_reset_pkg.sv */
package chip_reset_pkg;

  // bit positions inside the control words presented on the ports
  localparam int SW_SYS_RESET_BIT      = 8;
  localparam int HOST_POWER_INVERT_BIT = 0;
  localparam int TEST_SUPPLY_RST_BIT   = 1;
  localparam int CTRL_W                = 32;

  // timing
  localparam int MCLK_PERIOD_NS       = 40;
  localparam int STRETCH_TIME_NS      = 1000000;
  localparam int STRETCH_CYCLES_DFLT  = (STRETCH_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SYNC_STAGES          = 2;
  localparam int NUM_BLOCKS_DFLT      = 8;
  localparam int WD_COUNT_W_DFLT      = 8;

  // supply monitor indications, all from outside the clock domain
  typedef struct packed {
    logic regulatorStable;  // internal regulator at target
    logic pllRailGood;      // pll rail at nominal level
    logic batteryGood;      // coin cell at or above its threshold
    logic mainPresent;      // main supply present
  } supply_s;

  typedef enum logic [1:0] {
    BAT_IDLE  = 2'b00,
    BAT_PULSE = 2'b01,
    BAT_HOLD  = 2'b10
  } bat_state_e;

endpackage : chip_reset_pkg

/* File: rtl/reset_release_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_release_sync
  import chip_reset_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input  wire logic mclk,
  input  wire logic assertIn,
  output logic      resetOut
);

  logic [STAGES-1:0] shift_q;
  logic [STAGES-1:0] shift_d;

  // assertion is immediate, release walks through the chain so it lands on a clock edge
  always_comb begin
    shift_d = {shift_q[STAGES-2:0], 1'b0};
  end

  always_ff @(posedge mclk or posedge assertIn) begin
    if (assertIn) begin
      shift_q <= '1;
    end else begin
      shift_q <= shift_d;
    end
  end

  assign resetOut = shift_q[STAGES-1];

endmodule : reset_release_sync
`default_nettype wire

/* File: rtl/chip_reset_generator.sv */
// Functional notes
// - battery reset pulse on main rise if battery low
// - battery swap without main holds reset until main
// - no battery reset while main supply present, except the main-rise pulse
// - main-supply reset from regulator and pll rail
// - separate main-supply reset for surviving registers
// - system reset from all five sources
// - host power reset follows system reset
// - host reset on system, power-good low, invert
// - watchdog keeps its count and battery logic
// - glitch protection not armed by watchdog
// - watchdog reset sets sticky watchdog flag
// - no-watchdog reset only main supply or pin
// - processor reset stretched 1 ms after system
// - block reset needs enable bit and unlock
// - test bit forces main-supply reset
`timescale 1ns/1ps
`default_nettype none
module chip_reset_generator
  import chip_reset_pkg::*;
#(
  parameter int NUM_BLOCKS     = NUM_BLOCKS_DFLT,
  parameter int STRETCH_CYCLES = STRETCH_CYCLES_DFLT,
  parameter int WD_COUNT_W     = WD_COUNT_W_DFLT
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire supply_s                supplies,
  input  wire logic                   externalResetInN,
  input  wire logic                   hostPowerGood,
  input  wire logic                   watchdogEvent,
  input  wire logic                   coreResetRequest,
  input  wire logic [CTRL_W-1:0]      systemResetCtl,
  input  wire logic [CTRL_W-1:0]      powerResetCtl,
  input  wire logic [CTRL_W-1:0]      hostGlobalTest,
  input  wire logic [NUM_BLOCKS-1:0]  blockResetEnable,
  input  wire logic                   resetEnableUnlocked,
  input  wire logic                   watchdogFlagClear,
  output logic                        batteryReset,
  output logic                        mainSupplyReset,
  output logic                        systemReset,
  output logic                        hostPowerReset,
  output logic                        hostReset,
  output logic                        systemResetNoWatchdog,
  output logic                        processorReset,
  output logic                        glitchGuardActive,
  output logic [NUM_BLOCKS-1:0]       blockReset,
  output logic                        watchdogFlag,
  output logic [WD_COUNT_W-1:0]       watchdogCount
);

  localparam int PIN_W = 6;
  localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CNT_W-1:0] STRETCH_LOAD = CNT_W'(STRETCH_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [SYNC_STAGES-1:0] rstnSync_q;
  logic                   rstnInt;
  logic [PIN_W-1:0]       pinRaw;
  logic [PIN_W-1:0]       pinA_q;
  logic [PIN_W-1:0]       pinB_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstnSync_q <= '0;
    end else begin
      rstnSync_q <= {rstnSync_q[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rstnInt = rstnSync_q[SYNC_STAGES-1];

  assign pinRaw = {supplies, externalResetInN, hostPowerGood};

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rstnInt) begin
    if (!rstnInt) begin
      pinA_q <= '0;
      pinB_q <= '0;
    end else begin
      pinA_q <= pinRaw;
      pinB_q <= pinA_q;
    end
  end

  supply_s supS;
  logic    extNS;
  logic    hostGoodS;
  assign {supS, extNS, hostGoodS} = pinB_q;

  ////////////////////////////////////////////////////////////////////////////
  // battery-domain reset

  bat_state_e batState_q;
  bat_state_e batState_d;
  logic       mainPrev_q;
  logic       batPrev_q;
  logic       batteryReset_q;
  logic       batteryReset_d;
  logic       mainRise;
  logic       batRise;

  assign mainRise = supS.mainPresent & ~mainPrev_q;
  assign batRise  = supS.batteryGood & ~batPrev_q;

  always_comb begin
    batState_d = batState_q;
    unique case (batState_q)
      BAT_IDLE: begin
        if (mainRise && !supS.batteryGood) begin
          batState_d = BAT_PULSE;
        end else if (!supS.mainPresent && batRise) begin
          batState_d = BAT_HOLD;
        end
      end
      BAT_PULSE: begin
        batState_d = BAT_IDLE;
      end
      BAT_HOLD: begin
        if (supS.mainPresent) begin
          batState_d = BAT_IDLE;
        end
      end
      default: begin
        batState_d = BAT_IDLE;
      end
    endcase
    // swaps and sags with main present fall through IDLE untouched
    batteryReset_d = (batState_d != BAT_IDLE);
  end

  always_ff @(posedge mclk or negedge rstnInt) begin
    if (!rstnInt) begin
      batState_q     <= BAT_IDLE;
      mainPrev_q     <= 1'b0;
      batPrev_q      <= 1'b0;
      batteryReset_q <= 1'b0;
    end else begin
      batState_q     <= batState_d;
      mainPrev_q     <= supS.mainPresent;
      batPrev_q      <= supS.batteryGood;
      batteryReset_q <= batteryReset_d;
    end
  end
  assign batteryReset = batteryReset_q;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources; every derived reset goes through a release synchroniser

  logic mainAssert;
  logic sysAssert;
  logic noWdAssert;
  logic hostAssert;
  logic procAssert;
  logic [CNT_W-1:0] stretch_q;
  logic [CNT_W-1:0] stretch_d;
  logic [NUM_BLOCKS-1:0] blockAssert;

  always_comb begin
    mainAssert = ~(supS.regulatorStable & supS.pllRailGood)
                 | hostGlobalTest[TEST_SUPPLY_RST_BIT];
    sysAssert  = mainAssert | ~extNS | watchdogEvent
                 | systemResetCtl[SW_SYS_RESET_BIT] | coreResetRequest;
    noWdAssert = mainAssert | ~extNS;
    hostAssert = sysAssert | ~hostGoodS | powerResetCtl[HOST_POWER_INVERT_BIT];
    procAssert = sysAssert | systemReset | (stretch_q != '0);
    blockAssert = blockResetEnable & {NUM_BLOCKS{resetEnableUnlocked}};
  end

  // counter reloads while system reset stands, so the stretch starts at its release
  always_comb begin
    if (systemReset) begin
      stretch_d = STRETCH_LOAD;
    end else if (stretch_q != '0) begin
      stretch_d = stretch_q - CNT_W'(1);
    end else begin
      stretch_d = stretch_q;
    end
  end

  always_ff @(posedge mclk or negedge rstnInt) begin
    if (!rstnInt) begin
      stretch_q <= STRETCH_LOAD;
    end else begin
      stretch_q <= stretch_d;
    end
  end

  // the main-supply copy is kept apart for registers outside system reset
  reset_release_sync u_mainSync (.mclk(mclk), .assertIn(mainAssert | ~rstnInt), .resetOut(mainSupplyReset));
  reset_release_sync u_sysSync  (.mclk(mclk), .assertIn(sysAssert | ~rstnInt),  .resetOut(systemReset));
  reset_release_sync u_vccSync  (.mclk(mclk), .assertIn(sysAssert | ~rstnInt),  .resetOut(hostPowerReset));
  reset_release_sync u_hostSync (.mclk(mclk), .assertIn(hostAssert | ~rstnInt), .resetOut(hostReset));
  reset_release_sync u_noWdSync (.mclk(mclk), .assertIn(noWdAssert | ~rstnInt), .resetOut(systemResetNoWatchdog));
  reset_release_sync u_procSync (.mclk(mclk), .assertIn(procAssert | ~rstnInt), .resetOut(processorReset));
  // glitch guard follows only supply and pin sources, never the watchdog
  reset_release_sync u_glSync   (.mclk(mclk), .assertIn(noWdAssert | ~rstnInt), .resetOut(glitchGuardActive));

  for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_block
    reset_release_sync u_blkSync (.mclk(mclk), .assertIn(blockAssert[i] | ~rstnInt), .resetOut(blockReset[i]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog record; count cleared only by the no-watchdog reset so it survives, flag also by watchdogFlagClear

  logic                  wdPrev_q;
  logic                  wdFlag_q;
  logic                  wdFlag_d;
  logic [WD_COUNT_W-1:0] wdCount_q;
  logic [WD_COUNT_W-1:0] wdCount_d;
  logic                  wdRise;

  assign wdRise = watchdogEvent & ~wdPrev_q;

  always_comb begin
    // set beats a clear arriving in the same cycle
    wdFlag_d  = wdRise | (wdFlag_q & ~watchdogFlagClear);
    wdCount_d = wdCount_q;
    if (wdRise && (wdCount_q != '1)) begin
      wdCount_d = wdCount_q + WD_COUNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge systemResetNoWatchdog) begin
    if (systemResetNoWatchdog) begin
      wdPrev_q  <= 1'b0;
      wdFlag_q  <= 1'b0;
      wdCount_q <= '0;
    end else begin
      wdPrev_q  <= watchdogEvent;
      wdFlag_q  <= wdFlag_d;
      wdCount_q <= wdCount_d;
    end
  end
  assign watchdogFlag  = wdFlag_q;
  assign watchdogCount = wdCount_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstnInt);

  a_bat_pulse_once: assert property ((batState_q == BAT_IDLE) && mainRise && !supS.batteryGood
                                     |=> batteryReset ##1 !batteryReset) else $error("battery pulse wrong");
  a_bat_hold_level: assert property ((batState_q == BAT_HOLD) && !supS.mainPresent
                                     |=> batteryReset) else $error("battery hold lost");
  a_bat_quiet_main: assert property (mainPrev_q && supS.mainPresent && (batState_q == BAT_IDLE)
                                     |=> !batteryReset) else $error("battery reset with main");
  a_main_sources:   assert property (mainAssert |=> mainSupplyReset) else $error("main reset missed");
  a_test_force:     assert property (hostGlobalTest[TEST_SUPPLY_RST_BIT] |=> mainSupplyReset)
                      else $error("test force ignored");
  a_sys_sources:    assert property (sysAssert |=> systemReset && hostPowerReset) else $error("system reset missed");
  a_host_power:     assert property (hostPowerReset == systemReset) else $error("host power differs");
  a_host_sources:   assert property (!hostGoodS || powerResetCtl[HOST_POWER_INVERT_BIT] || sysAssert
                                     |=> hostReset) else $error("host reset missed");
  a_nowd_quiet:     assert property (!noWdAssert [*3] |-> !systemResetNoWatchdog)
                      else $error("no-watchdog reset by other source");
  a_glitch_quiet:   assert property (!noWdAssert [*3] |-> !glitchGuardActive) else $error("glitch armed");
  // a no-watchdog reset still standing holds the flag clear for its last edge
  a_wd_flag_set:    assert property (wdRise && !noWdAssert && !systemResetNoWatchdog
                                     |=> watchdogFlag) else $error("watchdog flag missed");
  a_proc_stretch:   assert property ($fell(systemReset) |-> processorReset [*8]) else $error("processor not held");
  a_proc_release:   assert property ($fell(processorReset) |-> (stretch_q == '0) && !systemReset)
                      else $error("processor released early");
  a_block_gate:     assert property ((blockAssert == '0) [*3] |-> (blockReset == '0))
                      else $error("block reset without enable");
  a_sync_release:   assert property ($fell(systemReset) |-> !$past(sysAssert, 2)) else $error("release not synced");

endmodule : chip_reset_generator
`default_nettype wire

/* File: verification/far_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import chip_reset_pkg::*;
(
  input  wire logic    mclk,
  input  wire supply_s wantSup,
  input  wire logic    wantPin,
  input  wire logic    wantPg,
  input  wire logic    wdKick,
  input  wire logic    wantCore,
  output var supply_s  supplies,
  output logic         externalResetInN,
  output logic         hostPowerGood,
  output logic         watchdogEvent,
  output logic         coreResetRequest
);
  // every level moves just after an edge, never between edges
  initial begin
    supplies         = 4'hF;
    externalResetInN = 1'b1;
    hostPowerGood    = 1'b1;
    watchdogEvent    = 1'b0;
    coreResetRequest = 1'b0;
  end
  // one kick gives one single-cycle event, so a count of events is exact
  always @(posedge mclk) begin
    supplies         <= wantSup;
    externalResetInN <= wantPin;
    hostPowerGood    <= wantPg;
    watchdogEvent    <= wdKick;
    coreResetRequest <= wantCore;
  end
endmodule : far_side_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import chip_reset_pkg::*;
  localparam int STR = 16;
  logic              mclk = 1'b0;
  logic              rstn = 1'b0;
  supply_s           wantSup = 4'hF;
  logic              wantPin = 1'b1;
  logic              wantPg = 1'b1;
  logic              wdKick = 1'b0;
  logic              wantCore = 1'b0;
  supply_s           supplies;
  logic              externalResetInN, hostPowerGood, watchdogEvent, coreResetRequest;
  logic [CTRL_W-1:0] systemResetCtl = '0;
  logic [CTRL_W-1:0] powerResetCtl = '0;
  logic [CTRL_W-1:0] hostGlobalTest = '0;
  logic [7:0]        blockResetEnable = 8'h00;
  logic              resetEnableUnlocked = 1'b0;
  logic              watchdogFlagClear = 1'b0;
  logic              batteryReset, mainSupplyReset, systemReset, hostPowerReset, hostReset;
  logic              systemResetNoWatchdog, processorReset, glitchGuardActive, watchdogFlag;
  logic [7:0]        blockReset, watchdogCount;
  logic [7:0]        batHigh = 8'h00;
  logic [7:0]        base;
  int                err_total = 0;
  int                compares = 0;

  always #20 mclk = ~mclk;
  // counts battery reset cycles so pulse width and absence can be judged
  always @(posedge mclk) batHigh <= batHigh + {7'h00, batteryReset};

  far_side_model far_side_model_i (.mclk(mclk), .wantSup(wantSup), .wantPin(wantPin), .wantPg(wantPg),
    .wdKick(wdKick), .wantCore(wantCore), .supplies(supplies), .externalResetInN(externalResetInN),
    .hostPowerGood(hostPowerGood), .watchdogEvent(watchdogEvent), .coreResetRequest(coreResetRequest));

  chip_reset_generator #(.NUM_BLOCKS(8), .STRETCH_CYCLES(STR), .WD_COUNT_W(8)) chip_reset_generator_i (
    .mclk(mclk), .rstn(rstn), .supplies(supplies), .externalResetInN(externalResetInN),
    .hostPowerGood(hostPowerGood), .watchdogEvent(watchdogEvent), .coreResetRequest(coreResetRequest),
    .systemResetCtl(systemResetCtl), .powerResetCtl(powerResetCtl), .hostGlobalTest(hostGlobalTest),
    .blockResetEnable(blockResetEnable), .resetEnableUnlocked(resetEnableUnlocked),
    .watchdogFlagClear(watchdogFlagClear), .batteryReset(batteryReset), .mainSupplyReset(mainSupplyReset),
    .systemReset(systemReset), .hostPowerReset(hostPowerReset), .hostReset(hostReset),
    .systemResetNoWatchdog(systemResetNoWatchdog), .processorReset(processorReset),
    .glitchGuardActive(glitchGuardActive), .blockReset(blockReset), .watchdogFlag(watchdogFlag),
    .watchdogCount(watchdogCount));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // wide enough for the flag and count together
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    tick(12);
    rstn <= 1'b1;
    tick(40); #1;
    chk({batteryReset, mainSupplyReset, systemReset, processorReset}, 4'h0);
    tick(1); wantCore <= 1'b1;
    tick(2); #1;
    chk({systemReset, hostPowerReset, hostReset, processorReset, systemResetNoWatchdog}, 5'b11110);
    tick(1); wantCore <= 1'b0;
    tick(6); #1;
    chk({systemReset, processorReset}, 2'b01);
    tick(STR + 8); #1;
    chk(processorReset, 1'b0);
    tick(1); systemResetCtl[SW_SYS_RESET_BIT] <= 1'b1;
    tick(1); #1;
    chk({systemReset, hostPowerReset}, 2'b11);
    tick(1); systemResetCtl[SW_SYS_RESET_BIT] <= 1'b0;
    for (int i = 1; i <= 2; i++) begin
      tick(STR + 30); wdKick <= 1'b1;
      tick(1); wdKick <= 1'b0; #1;
      chk({systemReset, glitchGuardActive, systemResetNoWatchdog}, 3'b100);
      tick(6); #1;
      chk({watchdogFlag, watchdogCount}, {1'b1, 8'(i)});
    end
    tick(1); watchdogFlagClear <= 1'b1;
    tick(1); watchdogFlagClear <= 1'b0;
    tick(2); #1;
    chk({watchdogFlag, watchdogCount}, {1'b0, 8'h02});
    tick(STR + 30); wantPin <= 1'b0;
    tick(6); #1;
    chk({systemResetNoWatchdog, systemReset, glitchGuardActive}, 3'b111);
    tick(1); wantPin <= 1'b1;
    tick(STR + 30); #1;
    chk(watchdogCount, 8'h00);
    for (int k = 0; k < 3; k++) begin
      tick(1);
      if (k == 0) wantSup.regulatorStable <= 1'b0;
      else if (k == 1) wantSup.pllRailGood <= 1'b0;
      else hostGlobalTest[TEST_SUPPLY_RST_BIT] <= 1'b1;
      tick(6); #1;
      chk({mainSupplyReset, systemResetNoWatchdog, systemReset}, 3'b111);
      tick(1); wantSup <= 4'hF; hostGlobalTest <= '0;
      tick(STR + 30); #1;
      chk({mainSupplyReset, systemReset}, 2'b00);
    end
    tick(1); wantPg <= 1'b0;
    tick(6); #1;
    chk({hostReset, systemReset, hostPowerReset}, 3'b100);
    tick(1); wantPg <= 1'b1;
    tick(6); #1;
    chk(hostReset, 1'b0);
    tick(1); powerResetCtl[HOST_POWER_INVERT_BIT] <= 1'b1;
    tick(3); #1;
    chk(hostReset, 1'b1);
    tick(1); powerResetCtl <= '0; blockResetEnable <= 8'hA5;
    tick(4); #1;
    chk(blockReset, 8'h00);
    tick(1); resetEnableUnlocked <= 1'b1;
    tick(4); #1;
    chk(blockReset, 8'hA5);
    tick(1); wantSup <= 4'b1100;
    tick(6); wantSup.batteryGood <= 1'b1;
    tick(6); #1;
    chk(batteryReset, 1'b1);
    tick(1); wantSup.mainPresent <= 1'b1;
    tick(6); #1;
    chk(batteryReset, 1'b0);
    tick(1); wantSup <= 4'b1100;
    tick(6); base = batHigh; wantSup.mainPresent <= 1'b1;
    tick(8); #1;
    chk(batHigh - base, 8'h01);
    tick(1); base = batHigh; wantSup.batteryGood <= 1'b1;
    tick(6); wantSup.batteryGood <= 1'b0;
    tick(6); #1;
    chk(batHigh - base, 8'h00);
    results();
  end

  // the tests need well under a thousand cycles; this bound cuts a hang short
  initial begin
    repeat (4000) @(posedge mclk);
    err_total++;
    results();
  end
endmodule : tb_top
`default_nettype wire
